// *** hw/pswc_cfg.svh ***
// Offsets, field positions and reset values of the sleep controller.
// Included by bare name; definitions only.
`ifndef PSWC_CFG_SVH
`define PSWC_CFG_SVH
`define PSWC_OFS_CTRL 12'h000
`define PSWC_OFS_STAT 12'h004
`define PSWC_CTRL_DEEP 0
`define PSWC_CTRL_EXIT 1
`define PSWC_STAT_SLEEP 0
`define PSWC_STAT_DEEP 1
`define PSWC_STAT_EVT 2
`define PSWC_STAT_EVWAIT 3
`define PSWC_CTRL_RST 2'h0
`define PSWC_EVT_RST 1'b0
`endif

// *** hw/pswc_pkg.sv ***
// Types shared by the sleep controller files.
// Assumes nothing of its surroundings.
package pswc_pkg;
    typedef enum logic [1:0] {
        RUN,
        SLEEP_IRQ,
        SLEEP_EVT
    } pswc_state_t;
endpackage

// *** hw/pswc_evt_if.sv ***
// Set, clear and value of the one-bit event register.
// Assumes owner and user share one clock.
`timescale 1ns/1ps
interface pswc_evt_if;
    logic setEvt;
    logic clrEvt;
    logic evtVal;
    modport owner (input setEvt, input clrEvt, output evtVal);
    modport user (output setEvt, output clrEvt, input evtVal);
endinterface

// *** hw/pswc_event_reg.sv ***
// One-bit event register behind the wait-for-event instruction.
// Assumes synchronous active-high reset on the core clock.
`timescale 1ns/1ps
`include "pswc_cfg.svh"
module pswc_event_reg (
    input wire logic clk,
    input wire logic srst,
    pswc_evt_if.owner evt
);
    logic evt_reg;
    logic evt_next;

    // Set beats clear so an event in the consuming cycle survives
    assign evt_next = evt.setEvt ? 1'b1 : (evt.clrEvt ? 1'b0 : evt_reg);
    assign evt.evtVal = evt_reg;

    // Storage
    always_ff @(posedge clk) begin
        if (srst) begin
            evt_reg <= `PSWC_EVT_RST;
        end else begin
            evt_reg <= evt_next;
        end
    end
endmodule

// *** hw/pswc_top.sv ***
// Sleep entry and wakeup control of a processor core, with APB registers.
// Assumes the core pulses one instruction strobe per cycle at most.
`timescale 1ns/1ps
`include "pswc_cfg.svh"
module pswc_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic waitInterruptInstr,
    input wire logic waitEventInstr,
    input wire logic handlerExit,
    input wire logic excEntryReq,
    input wire logic irqAboveCurrent,
    input wire logic irqMaskBit,
    input wire logic faultMaskBit,
    input wire logic extEvent,
    input wire logic sendEventIn,
    input wire logic debugWake,
    output logic haltExec,
    output logic returnToThread,
    output logic handlerHold,
    output logic procClkStop,
    output logic sysClkStop,
    output logic pllOff,
    output logic flashOff,
    output logic eventFlag
);
    pswc_pkg::pswc_state_t state_reg;
    pswc_pkg::pswc_state_t state_next;
    logic [1:0] ctrl_reg;
    logic [1:0] ctrl_next;
    logic deep_reg;
    logic deep_next;
    logic [31:0] rdata_reg;
    logic procStop_reg;
    logic sysStop_reg;
    pswc_evt_if evtBus ();

    // Event register lives in its own small module
    pswc_event_reg u_evt (
        .clk(clk),
        .srst(srst),
        .evt(evtBus)
    );

    // Control fields
    wire deepSleepSelect = ctrl_reg[`PSWC_CTRL_DEEP];
    wire sleepOnHandlerExit = ctrl_reg[`PSWC_CTRL_EXIT];

    // APB decode; one access cycle, no wait states
    wire setupPh = psel & ~penable;
    wire accessPh = psel & penable;
    wire hitCtrl = paddr == `PSWC_OFS_CTRL;
    wire hitStat = paddr == `PSWC_OFS_STAT;
    wire mapped = hitCtrl | hitStat;
    wire ctrlWr = accessPh & pwrite & hitCtrl;
    assign pready = accessPh;
    assign pslverr = accessPh & ~mapped;
    assign prdata = rdata_reg;

    // Sleep state decode
    wire running = state_reg == pswc_pkg::RUN;
    wire inIrqSleep = state_reg == pswc_pkg::SLEEP_IRQ;
    wire inEvtSleep = state_reg == pswc_pkg::SLEEP_EVT;
    wire evtNow = evtBus.evtVal;

    // Masked but eligible interrupt still wakes the core
    wire maskedWake = irqMaskBit & ~faultMaskBit & irqAboveCurrent;
    wire excWake = excEntryReq | maskedWake;
    wire linkEvent = extEvent | sendEventIn;
    wire wakeIrq = inIrqSleep & (excWake | debugWake);
    wire wakeEvt = inEvtSleep & (excWake | linkEvent | debugWake);

    // Entry requests while running
    wire enterWfi = running & waitInterruptInstr;
    wire enterWfe = running & ~waitInterruptInstr & waitEventInstr
        & ~evtNow;
    wire passWfe = running & ~waitInterruptInstr & waitEventInstr
        & evtNow;
    wire enterExit = running & ~waitInterruptInstr & ~waitEventInstr
        & handlerExit & sleepOnHandlerExit;
    wire entering = enterWfi | enterWfe | enterExit;

    // Event register hookup; an event that wakes an event-wait is used up
    assign evtBus.setEvt = linkEvent & ~inEvtSleep;
    assign evtBus.clrEvt = passWfe;

    // Core-facing handshakes
    assign haltExec = entering | ~running;
    assign returnToThread = enterExit;
    assign handlerHold = maskedWake & ~excEntryReq & running;
    assign eventFlag = evtNow;

    // Clock and power controls come from flops
    assign procClkStop = procStop_reg;
    assign sysClkStop = sysStop_reg;
    assign pllOff = sysStop_reg;
    assign flashOff = sysStop_reg;

    // Next sleep state; RUN always reachable again after a wake
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            pswc_pkg::RUN: begin
                if (enterWfi | enterExit) begin
                    state_next = pswc_pkg::SLEEP_IRQ;
                end else if (enterWfe) begin
                    state_next = pswc_pkg::SLEEP_EVT;
                end
            end
            pswc_pkg::SLEEP_IRQ: begin
                if (wakeIrq) begin
                    state_next = pswc_pkg::RUN;
                end
            end
            pswc_pkg::SLEEP_EVT: begin
                if (wakeEvt) begin
                    state_next = pswc_pkg::RUN;
                end
            end
            default: begin
                state_next = pswc_pkg::RUN;
            end
        endcase
    end

    // Depth is fixed at entry so a later write cannot half-wake the chip
    assign deep_next = entering ? deepSleepSelect : deep_reg;
    assign ctrl_next = ctrlWr ? pwdata[1:0] : ctrl_reg;

    // Sleep state and depth
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= pswc_pkg::RUN;
            deep_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            deep_reg <= deep_next;
        end
    end

    // Clock and power outputs follow the next state
    always_ff @(posedge clk) begin
        if (srst) begin
            procStop_reg <= 1'b0;
            sysStop_reg <= 1'b0;
        end else begin
            procStop_reg <= state_next != pswc_pkg::RUN;
            sysStop_reg <= (state_next != pswc_pkg::RUN) & deep_next;
        end
    end

    // Control register write
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_reg <= `PSWC_CTRL_RST;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Read data captured in setup, held through the access cycle
    wire [31:0] statWord = {28'h0000000, inEvtSleep, evtNow, deep_reg,
        ~running};
    wire [31:0] rdSel = hitCtrl ? {30'h00000000, ctrl_reg} :
        (hitStat ? statWord : 32'h00000000);
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_reg <= 32'h00000000;
        end else if (setupPh) begin
            rdata_reg <= rdSel;
        end
    end

    // Checks on the sleep behaviour
    property p_clk_stop;
        @(posedge clk) disable iff (srst)
        procClkStop == ~running && sysClkStop == (~running & deep_reg)
        && pllOff == sysClkStop && flashOff == sysClkStop;
    endproperty
    a_clk_stop: assert property (p_clk_stop)
        else $error("clock stop outputs disagree with sleep state");

    // System clock never stops while the core clock still runs
    property p_deep_nest;
        @(posedge clk) disable iff (srst)
        sysClkStop |-> procClkStop;
    endproperty
    a_deep_nest: assert property (p_deep_nest)
        else $error("system clock stopped alone");

    // Bus answers in the access cycle; no wait states inserted
    property p_ready;
        @(posedge clk) disable iff (srst)
        psel && penable |-> pready && (pslverr == !mapped);
    endproperty
    a_ready: assert property (p_ready) else $error("apb answer");

    // Control write lands at the access edge
    property p_ctrl_wr;
        @(posedge clk) disable iff (srst)
        ctrlWr |=> ctrl_reg == $past(pwdata[1:0]);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("ctrl lost");

    property p_depth;
        @(posedge clk) disable iff (srst)
        entering |=> deep_reg == $past(deepSleepSelect) && sysClkStop
            == $past(deepSleepSelect);
    endproperty
    a_depth: assert property (p_depth) else $error("wrong depth");

    property p_wfi;
        @(posedge clk) disable iff (srst)
        running && waitInterruptInstr |-> haltExec ##1 inIrqSleep;
    endproperty
    a_wfi: assert property (p_wfi) else $error("wfi no sleep");

    // A stopped core clock always comes with a halted core
    property p_halt_asleep;
        @(posedge clk) disable iff (srst)
        procClkStop |-> haltExec;
    endproperty
    a_halt_asleep: assert property (p_halt_asleep)
        else $error("core runs while clock stopped");

    property p_wfe_sleep;
        @(posedge clk) disable iff (srst)
        running && !waitInterruptInstr && waitEventInstr && !eventFlag
            |-> haltExec ##1 inEvtSleep && procClkStop;
    endproperty
    a_wfe_sleep: assert property (p_wfe_sleep) else $error("wfe");

    property p_wfe_pass;
        @(posedge clk) disable iff (srst)
        running && !waitInterruptInstr && waitEventInstr && eventFlag
            && !extEvent && !sendEventIn |-> !haltExec ##1 running
            && !eventFlag;
    endproperty
    a_wfe_pass: assert property (p_wfe_pass) else $error("wfe pass");

    // Event in the consuming cycle survives; set beats clear
    property p_set_wins;
        @(posedge clk) disable iff (srst)
        running && !waitInterruptInstr && waitEventInstr && eventFlag
            && extEvent |=> eventFlag && running;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("evt eaten");

    property p_exit;
        @(posedge clk) disable iff (srst)
        running && !waitInterruptInstr && !waitEventInstr && handlerExit
            && sleepOnHandlerExit |-> returnToThread ##1 inIrqSleep;
    endproperty
    a_exit: assert property (p_exit) else $error("no sleep on exit");

    // Return strobe only in a sleep-on-exit entry cycle
    property p_ret_only;
        @(posedge clk) disable iff (srst)
        returnToThread |-> running && handlerExit && sleepOnHandlerExit;
    endproperty
    a_ret_only: assert property (p_ret_only) else $error("stray ret");

    property p_irq_hold;
        @(posedge clk) disable iff (srst)
        inIrqSleep && !excEntryReq && !maskedWake && !debugWake
            |=> inIrqSleep [*1];
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("early");

    property p_masked;
        @(posedge clk) disable iff (srst)
        inIrqSleep && irqMaskBit && !faultMaskBit && irqAboveCurrent
            && !excEntryReq ##1 irqMaskBit && !faultMaskBit
            && irqAboveCurrent && !excEntryReq |-> running && handlerHold;
    endproperty
    a_masked: assert property (p_masked) else $error("mask wake");

    property p_evt_wake;
        @(posedge clk) disable iff (srst)
        inEvtSleep && (extEvent || sendEventIn) |=> running && !eventFlag;
    endproperty
    a_evt_wake: assert property (p_evt_wake) else $error("evt");

    // Event-wait sleep holds while no wake source is present
    property p_evt_hold;
        @(posedge clk) disable iff (srst)
        inEvtSleep && !excWake && !linkEvent && !debugWake |=> inEvtSleep;
    endproperty
    a_evt_hold: assert property (p_evt_hold) else $error("evt early");

    property p_spurious;
        @(posedge clk) disable iff (srst)
        !running && debugWake |=> running && (haltExec == (waitInterruptInstr
            || (waitEventInstr && !eventFlag)
            || (handlerExit && sleepOnHandlerExit)));
    endproperty
    a_spurious: assert property (p_spurious) else $error("dbg");

    property p_evt_set;
        @(posedge clk) disable iff (srst)
        running && extEvent |=> eventFlag;
    endproperty
    a_evt_set: assert property (p_evt_set) else $error("evt lost");

    c_deep: cover property (@(posedge clk) disable iff (srst)
        enterWfi && deepSleepSelect ##1 sysClkStop);
    c_evt_cycle: cover property (@(posedge clk) disable iff (srst)
        enterWfe ##[1:20] wakeEvt);
    c_exit: cover property (@(posedge clk) disable iff (srst)
        enterExit ##[1:20] wakeIrq);
    c_masked: cover property (@(posedge clk) disable iff (srst)
        inIrqSleep && maskedWake ##1 handlerHold);
endmodule

// *** dv/pswc_core_model.sv ***
// Exception controller and neighbour processor beside the sleep block.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module pswc_core_model (
    input wire logic clk,
    output logic excEntryReq,
    output logic irqAboveCurrent,
    output logic sendEventIn
);
    // Quiet until commanded
    initial begin
        excEntryReq = 1'b0;
        irqAboveCurrent = 1'b0;
        sendEventIn = 1'b0;
    end
    // One-cycle pending exception; lag models a slow controller
    task automatic fire_exc(input int lag);
        @(posedge clk);
        repeat (lag) @(posedge clk);
        excEntryReq <= 1'b1;
        @(posedge clk);
        excEntryReq <= 1'b0;
    endtask
    // Send-event pulse of the other processor
    task automatic fire_sev();
        @(posedge clk);
        sendEventIn <= 1'b1;
        @(posedge clk);
        sendEventIn <= 1'b0;
    endtask
    // Enabled interrupt above current priority, held as a level
    task automatic set_irq(input logic v);
        @(posedge clk);
        irqAboveCurrent <= v;
    endtask
endmodule

// *** dv/pswc_top_test.sv ***
// Self-checking bench of the sleep controller.
// Assumes zero-wait APB and the core model beside the block.
`timescale 1ns/1ps
`include "pswc_cfg.svh"
module pswc_top_test;
    logic clk, srst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] stb; // wfi, wfe, exit, ext event, debug
    logic irqMaskBit, faultMaskBit, excEntryReq, irqAbove, send_event_instr;
    logic haltExec, retThr, hold, procStop, sysStop, pllOff, flashOff, evf;
    int error_cnt = 0;
    int n_compared = 0;
    pswc_core_model core (.clk(clk), .excEntryReq(excEntryReq),
        .irqAboveCurrent(irqAbove), .sendEventIn(send_event_instr));
    pswc_top dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .waitInterruptInstr(stb[0]),
        .waitEventInstr(stb[1]), .handlerExit(stb[2]),
        .excEntryReq(excEntryReq), .irqAboveCurrent(irqAbove),
        .irqMaskBit(irqMaskBit), .faultMaskBit(faultMaskBit),
        .extEvent(stb[3]), .sendEventIn(send_event_instr), .debugWake(stb[4]),
        .haltExec(haltExec), .returnToThread(retThr), .handlerHold(hold),
        .procClkStop(procStop), .sysClkStop(sysStop), .pllOff(pllOff),
        .flashOff(flashOff), .eventFlag(evf));
    // Free-running core clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One APB transfer; request held until pready seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        chk(pslverr, err);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Strobe k for one cycle, judge halt, return and sleep
    task automatic enter(input int k, input logic h, input logic r,
                         input logic s);
        @(posedge clk);
        stb[k] <= 1'b1;
        @(negedge clk);
        chk(haltExec, h);
        chk(retThr, r);
        @(posedge clk);
        stb <= 5'h00;
        @(negedge clk);
        chk(procStop, s);
    endtask
    task automatic sleeps(input logic p, input logic d);
        @(negedge clk);
        chk({procStop, sysStop, pllOff, flashOff}, {p, d, d, d});
    endtask
    task automatic t_regs();
        apb(1'b0, `PSWC_OFS_CTRL, 32'h0, 1'b0);
        chk(rd, 32'h0);
        apb(1'b1, `PSWC_OFS_CTRL, 32'hFFFFFFFF, 1'b0);
        apb(1'b1, `PSWC_OFS_STAT, 32'hF, 1'b0);
        apb(1'b0, `PSWC_OFS_CTRL, 32'h0, 1'b0);
        chk(rd, 32'h3);
        apb(1'b0, `PSWC_OFS_STAT, 32'h0, 1'b0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h008, 32'h0, 1'b1);
        chk(rd, 32'h0);
    endtask
    task automatic t_wfi(input logic deep);
        apb(1'b1, `PSWC_OFS_CTRL, {31'h0, deep}, 1'b0);
        enter(0, 1'b1, 1'b0, 1'b1);
        sleeps(1'b1, deep);
        core.fire_exc(3);
        sleeps(1'b0, 1'b0);
    endtask
    task automatic t_wfe();
        enter(1, 1'b1, 1'b0, 1'b1);
        core.fire_sev();
        sleeps(1'b0, 1'b0);
        enter(1, 1'b1, 1'b0, 1'b1);
        enter(3, 1'b1, 1'b0, 1'b0);
        sleeps(1'b0, 1'b0);
        enter(3, 1'b0, 1'b0, 1'b0);
        chk(evf, 1'b1);
        enter(1, 1'b0, 1'b0, 1'b0);
        chk(evf, 1'b0);
    endtask
    task automatic t_exit();
        enter(2, 1'b0, 1'b0, 1'b0);
        apb(1'b1, `PSWC_OFS_CTRL, 32'h2, 1'b0);
        enter(2, 1'b1, 1'b1, 1'b1);
        enter(4, 1'b1, 1'b0, 1'b0);
        enter(0, 1'b1, 1'b0, 1'b1);
        core.fire_exc(0);
        sleeps(1'b0, 1'b0);
    endtask
    // Fault mask blocks the wake; dropping it lets the masked irq wake
    task automatic t_mask();
        @(posedge clk);
        irqMaskBit <= 1'b1;
        faultMaskBit <= 1'b1;
        enter(0, 1'b1, 1'b0, 1'b1);
        core.set_irq(1'b1);
        repeat (3) @(posedge clk);
        sleeps(1'b1, 1'b0);
        @(posedge clk);
        faultMaskBit <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk({procStop, hold}, 2'b01);
        @(posedge clk);
        irqMaskBit <= 1'b0;
        @(negedge clk);
        chk(hold, 1'b0);
        core.set_irq(1'b0);
    endtask
    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
    initial begin
        {srst, psel, penable, pwrite} = 4'hF;
        {psel, penable, pwrite, irqMaskBit, faultMaskBit} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        stb = 5'h00;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_wfi(1'b0);
        t_wfi(1'b1);
        t_wfe();
        t_exit();
        t_mask();
        give_verdict();
    end
endmodule
